// ===== vic_top.sv
// vectored interrupt controller register interface and request lines
`timescale 1ns/100ps
module vic_top import vic_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [NUM_SRC-1:0] src_in,
    output logic [31:0] rd_data_out,
    output logic normal_request_line_n_out,
    output logic fast_request_line_n_out,
    output logic event_irq_out
);
    logic [31:0] mode_ff [NUM_SRC];
    logic [31:0] vector_ff [NUM_SRC];
    logic [31:0] spurious_vector_value_ff;
    logic [31:0] debug_ff;
    logic [NUM_SRC-1:0] enable_ff;
    logic [NUM_SRC-1:0] redirect_ff;
    logic [NUM_SRC-1:0] pend_ff;
    logic [4:0] stack_src_ff [STACK_DEPTH];
    logic [2:0] stack_lvl_ff [STACK_DEPTH];
    logic [DEPTH_W-1:0] depth_ff;
    logic [4:0] held_src_ff;
    logic held_valid_ff;
    logic [EV_W-1:0] event_ff;
    logic [EV_W-1:0] event_mask_ff;
    logic [31:0] rd_data_ff;
    logic normal_line_n_ff;
    logic fast_line_n_ff;
    logic event_irq_ff;

    logic [2*NUM_SRC-1:0] type_flat;
    logic [NUM_SRC-1:0] level_act;
    logic [NUM_SRC-1:0] edge_evt;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] cand;
    logic [11:0] ofs;
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic [5:0] win;
    logic win_found;
    logic [4:0] win_src;
    logic [2:0] top_lvl;
    logic [4:0] cur_src;
    logic normal_req;
    logic fast_req;
    logic push;
    logic [4:0] push_src;
    logic pop;
    logic [NUM_SRC-1:0] ack_vec;
    logic [EV_W-1:0] ev_set;
    logic [31:0] rd_mux;

    // highest level wins; the lower source number breaks a tie
    function automatic logic [5:0] pick_winner(input logic [NUM_SRC-1:0] req,
                                               input logic [3*NUM_SRC-1:0] lvls);
        logic [5:0] best;
        logic [2:0] best_lvl;
        best = 6'h00;
        best_lvl = 3'h0;
        for (int i = 1; i < NUM_SRC; i++) begin
            if (req[i] && (!best[5] || lvls[3*i +: 3] > best_lvl)) begin
                best = {1'b1, i[4:0]};
                best_lvl = lvls[3*i +: 3];
            end
        end
        return best;
    endfunction

    function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    logic [3*NUM_SRC-1:0] lvl_flat;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            type_flat[2*i +: 2] = mode_ff[i][TYPE_LSB +: TYPE_W];
            lvl_flat[3*i +: 3] = mode_ff[i][PRIO_LSB +: PRIO_W];
        end
    end

    vic_src_detect vic_src_detect_i (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .src_in(src_in),
        .type_in(type_flat),
        .level_act_out(level_act),
        .edge_out(edge_evt)
    );

    // address decode
    always_comb begin
        hit = addr_in[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS];
        ofs = addr_in[WIN_BITS-1:0];
        wr_hit = wr_en_in & hit;
        rd_hit = rd_en_in & hit;
    end

    // pending: level sources follow the line, edge sources hold the event
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            pending[i] = pend_ff[i] | (level_act[i] & ~mode_ff[i][TYPE_LSB]);
        end
        cand = pending & enable_ff & ~redirect_ff;
        cand[0] = 1'b0;
        win = pick_winner(cand, lvl_flat);
        top_lvl = (depth_ff == 4'h0) ? RST_LVL : stack_lvl_ff[3'(depth_ff - 4'h1)];
        cur_src = (depth_ff == 4'h0) ? RST_SRC : stack_src_ff[3'(depth_ff - 4'h1)];
        win_found = win[5] && (depth_ff == 4'h0 || lvl_flat[3*win[4:0] +: 3] > top_lvl);
        win_src = win[4:0];
        normal_req = win_found;
        fast_req = (pending[0] & enable_ff[0]) | (|(pending & enable_ff & redirect_ff));
    end

    // stacking happens on the vector read, or on a vector write in protect mode
    always_comb begin
        push = 1'b0;
        push_src = win_src;
        if (debug_ff[DBG_PROT_BIT]) begin
            push = wr_hit && is_ofs(ofs, OFS_NORMAL_VEC) && held_valid_ff;
            push_src = held_src_ff;
        end else begin
            push = rd_hit && is_ofs(ofs, OFS_NORMAL_VEC) && win_found;
        end
        pop = wr_hit && is_ofs(ofs, OFS_END_SERVICE) && depth_ff != 4'h0;
        ack_vec = RST_WORD;
        if (push) begin
            ack_vec[push_src] = 1'b1;
        end
        // fast vector read acknowledges source 0 but never a redirected source
        if (rd_hit && is_ofs(ofs, OFS_FAST_VEC) && pending[0] && enable_ff[0]) begin
            ack_vec[0] = 1'b1;
        end
        ev_set = '0;
        ev_set[EV_SPURIOUS_BIT] = rd_hit && is_ofs(ofs, OFS_NORMAL_VEC) && !win_found;
        ev_set[EV_STACK_BIT] = (wr_hit && is_ofs(ofs, OFS_END_SERVICE) && depth_ff == 4'h0)
                               || (push && depth_ff == DEPTH_W'(STACK_DEPTH));
    end

    // source mode and vector arrays
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                mode_ff[i] <= RST_WORD;
                vector_ff[i] <= RST_WORD;
            end
        end else if (wr_hit) begin
            if (ofs <= OFS_MODE_LAST) begin
                mode_ff[ofs[6:2]] <= wr_data_in & MODE_WR_MASK;
            end else if (ofs >= OFS_VEC_FIRST && ofs <= OFS_VEC_LAST) begin
                vector_ff[ofs[6:2]] <= wr_data_in;
            end
        end
    end

    // spurious vector and debug control
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            spurious_vector_value_ff <= RST_WORD;
            debug_ff <= RST_WORD;
        end else if (wr_hit) begin
            if (is_ofs(ofs, OFS_SPURIOUS)) begin
                spurious_vector_value_ff <= wr_data_in;
            end else if (is_ofs(ofs, OFS_DEBUG)) begin
                debug_ff <= wr_data_in & DBG_WR_MASK;
            end
        end
    end

    // enable and redirect sets; a zero written changes nothing
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            enable_ff <= RST_WORD;
            redirect_ff <= RST_WORD;
        end else if (wr_hit) begin
            if (is_ofs(ofs, OFS_ENABLE_CMD)) begin
                enable_ff <= enable_ff | wr_data_in;
            end else if (is_ofs(ofs, OFS_DISABLE_CMD)) begin
                enable_ff <= enable_ff & ~wr_data_in;
            end else if (is_ofs(ofs, OFS_FR_ENABLE)) begin
                redirect_ff <= redirect_ff | wr_data_in;
            end else if (is_ofs(ofs, OFS_FR_DISABLE)) begin
                redirect_ff <= redirect_ff & ~wr_data_in;
            end
        end
    end

    // a new edge or a set command wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pend_ff <= RST_WORD;
        end else begin
            pend_ff <= (pend_ff & ~ack_vec & ~((wr_hit && is_ofs(ofs, OFS_CLEAR_CMD)) ? wr_data_in : RST_WORD))
                       | edge_evt
                       | ((wr_hit && is_ofs(ofs, OFS_SET_CMD)) ? wr_data_in : RST_WORD);
        end
    end

    // priority stack; a push beyond its depth is dropped and flagged
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            depth_ff <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_src_ff[i] <= RST_SRC;
                stack_lvl_ff[i] <= RST_LVL;
            end
        end else if (push && depth_ff != DEPTH_W'(STACK_DEPTH)) begin
            stack_src_ff[3'(depth_ff)] <= push_src;
            stack_lvl_ff[3'(depth_ff)] <= lvl_flat[3*push_src +: 3];
            depth_ff <= depth_ff + 4'h1;
        end else if (pop) begin
            depth_ff <= depth_ff - 4'h1;
        end
    end

    // protect mode: a read only remembers the winner
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            held_src_ff <= RST_SRC;
            held_valid_ff <= 1'b0;
        end else if (rd_hit && is_ofs(ofs, OFS_NORMAL_VEC)) begin
            held_src_ff <= win_src;
            held_valid_ff <= win_found;
        end else if (push) begin
            held_valid_ff <= 1'b0;
        end
    end

    // block events: sticky, cleared by reading, set wins over the clear
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            event_ff <= '0;
            event_mask_ff <= '0;
        end else begin
            event_ff <= ((rd_hit && is_ofs(ofs, OFS_EVENT_STATUS)) ? '0 : event_ff) | ev_set;
            if (wr_hit && is_ofs(ofs, OFS_EVENT_MASK)) begin
                event_mask_ff <= wr_data_in[EV_W-1:0];
            end
        end
    end

    // read mux; reserved and unmapped words read zero
    always_comb begin
        rd_mux = RST_WORD;
        if (ofs <= OFS_MODE_LAST) begin
            rd_mux = mode_ff[ofs[6:2]];
        end else if (ofs >= OFS_VEC_FIRST && ofs <= OFS_VEC_LAST) begin
            rd_mux = vector_ff[ofs[6:2]];
        end else if (is_ofs(ofs, OFS_NORMAL_VEC)) begin
            rd_mux = win_found ? vector_ff[win_src] : spurious_vector_value_ff;
        end else if (is_ofs(ofs, OFS_FAST_VEC)) begin
            rd_mux = fast_req ? vector_ff[0] : spurious_vector_value_ff;
        end else if (is_ofs(ofs, OFS_CUR_STATUS)) begin
            rd_mux = {27'h0, cur_src};
        end else if (is_ofs(ofs, OFS_PENDING)) begin
            rd_mux = pending;
        end else if (is_ofs(ofs, OFS_MASK)) begin
            rd_mux = enable_ff;
        end else if (is_ofs(ofs, OFS_CORE_LINE)) begin
            rd_mux[CORE_FAST_BIT] = ~fast_line_n_ff;
            rd_mux[CORE_NORMAL_BIT] = ~normal_line_n_ff;
        end else if (is_ofs(ofs, OFS_SPURIOUS)) begin
            rd_mux = spurious_vector_value_ff;
        end else if (is_ofs(ofs, OFS_DEBUG)) begin
            rd_mux = debug_ff;
        end else if (is_ofs(ofs, OFS_FR_STATUS)) begin
            rd_mux = redirect_ff;
        end else if (is_ofs(ofs, OFS_EVENT_STATUS)) begin
            rd_mux[EV_W-1:0] = event_ff;
        end else if (is_ofs(ofs, OFS_EVENT_MASK)) begin
            rd_mux[EV_W-1:0] = event_mask_ff;
        end
    end

    // read data stand one cycle only, zero otherwise
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rd_data_ff <= RST_WORD;
        end else begin
            rd_data_ff <= rd_hit ? rd_mux : RST_WORD;
        end
    end

    // request lines; the general mask forces both inactive
    // kept active low so the pins need no gate after the flop
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            normal_line_n_ff <= 1'b1;
            fast_line_n_ff <= 1'b1;
            event_irq_ff <= 1'b0;
        end else begin
            normal_line_n_ff <= ~(normal_req & ~debug_ff[DBG_GMSK_BIT]);
            fast_line_n_ff <= ~(fast_req & ~debug_ff[DBG_GMSK_BIT]);
            event_irq_ff <= |(event_ff & event_mask_ff);
        end
    end

    assign rd_data_out = rd_data_ff;
    assign normal_request_line_n_out = normal_line_n_ff;
    assign fast_request_line_n_out = fast_line_n_ff;
    assign event_irq_out = event_irq_ff;
endmodule

// ===== vic_pkg.sv
// constants and register map of the vectored interrupt controller
package vic_pkg;
    localparam int NUM_SRC = 32;
    localparam logic [31:0] BASE_ADDR = 32'hFFFF_F000;
    localparam int WIN_BITS = 12;
    localparam logic [11:0] OFS_MODE_FIRST = 12'h000;
    localparam logic [11:0] OFS_MODE_LAST = 12'h07C;
    localparam logic [11:0] OFS_VEC_FIRST = 12'h080;
    localparam logic [11:0] OFS_VEC_LAST = 12'h0FC;
    localparam logic [11:0] OFS_NORMAL_VEC = 12'h100;
    localparam logic [11:0] OFS_FAST_VEC = 12'h104;
    localparam logic [11:0] OFS_CUR_STATUS = 12'h108;
    localparam logic [11:0] OFS_PENDING = 12'h10C;
    localparam logic [11:0] OFS_MASK = 12'h110;
    localparam logic [11:0] OFS_CORE_LINE = 12'h114;
    localparam logic [11:0] OFS_ENABLE_CMD = 12'h120;
    localparam logic [11:0] OFS_DISABLE_CMD = 12'h124;
    localparam logic [11:0] OFS_CLEAR_CMD = 12'h128;
    localparam logic [11:0] OFS_SET_CMD = 12'h12C;
    localparam logic [11:0] OFS_END_SERVICE = 12'h130;
    localparam logic [11:0] OFS_SPURIOUS = 12'h134;
    localparam logic [11:0] OFS_DEBUG = 12'h138;
    localparam logic [11:0] OFS_FR_ENABLE = 12'h140;
    localparam logic [11:0] OFS_FR_DISABLE = 12'h144;
    localparam logic [11:0] OFS_FR_STATUS = 12'h148;
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h150;
    localparam logic [11:0] OFS_EVENT_MASK = 12'h154;
    // mode register fields
    localparam int PRIO_LSB = 0;
    localparam int PRIO_W = 3;
    localparam int TYPE_LSB = 5;
    localparam int TYPE_W = 2;
    localparam logic [31:0] MODE_WR_MASK = 32'h0000_0067;
    // debug control fields
    localparam int DBG_PROT_BIT = 0;
    localparam int DBG_GMSK_BIT = 1;
    localparam logic [31:0] DBG_WR_MASK = 32'h0000_0003;
    // core line status fields
    localparam int CORE_FAST_BIT = 0;
    localparam int CORE_NORMAL_BIT = 1;
    // event status fields
    localparam int EV_W = 2;
    localparam int EV_SPURIOUS_BIT = 0;
    localparam int EV_STACK_BIT = 1;
    // sources that arrive on pins; the rest come from on-chip logic
    localparam logic [31:0] EXT_SRC_MASK = 32'hE000_0001;
    localparam int STACK_DEPTH = 8;
    localparam int DEPTH_W = 4;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [4:0] RST_SRC = 5'h00;
    localparam logic [2:0] RST_LVL = 3'h0;
endpackage

// ===== vic_src_detect.sv
// per-source level and edge detection with pin synchronisers
`timescale 1ns/100ps
module vic_src_detect import vic_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [NUM_SRC-1:0] src_in,
    input wire logic [2*NUM_SRC-1:0] type_in,
    output logic [NUM_SRC-1:0] level_act_out,
    output logic [NUM_SRC-1:0] edge_out
);
    logic [NUM_SRC-1:0] sync1_ff;
    logic [NUM_SRC-1:0] sync2_ff;
    logic [NUM_SRC-1:0] sync3_ff;
    logic [NUM_SRC-1:0] filt_ff;
    logic [NUM_SRC-1:0] prev_ff;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] clean;

    // three-stage synchroniser; only stage two and three are compared
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sync1_ff <= RST_WORD;
            sync2_ff <= RST_WORD;
            sync3_ff <= RST_WORD;
        end else begin
            sync1_ff <= src_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a pin change counts once stages two and three agree
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            filt_ff <= RST_WORD;
        end else begin
            filt_ff <= (filt_ff & ~(sync2_ff ~^ sync3_ff)) | (sync3_ff & (sync2_ff ~^ sync3_ff));
        end
    end

    always_comb begin
        clean = (filt_ff & EXT_SRC_MASK) | (src_in & ~EXT_SRC_MASK);
        for (int i = 0; i < NUM_SRC; i++) begin
            // internal sources have a fixed active sense
            raw[i] = clean[i];
            if (EXT_SRC_MASK[i] && !type_in[2*i+1]) begin
                raw[i] = ~clean[i];
            end
        end
    end

    // reset value of the history is inactive, so no edge appears at release
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            prev_ff <= RST_WORD;
        end else begin
            prev_ff <= raw;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            level_act_out[i] = raw[i] & ~type_in[2*i];
            edge_out[i] = raw[i] & ~prev_ff[i] & type_in[2*i];
        end
    end
endmodule

// ===== vic_assertions.sv
// concurrent checks on the register port and request lines of the controller
`timescale 1ns/100ps
module vic_assertions import vic_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [31:0] rd_data_out,
    input wire logic normal_request_line_n_out,
    input wire logic fast_request_line_n_out
);
    logic [31:0] en_sh_ff;
    logic [31:0] spu_sh_ff;
    logic [31:0] vec0_sh_ff;
    wire logic in_win = addr_in[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS];
    wire logic [11:0] ofs = addr_in[11:0];
    wire logic vec_hit = in_win && ofs[11:7] == 5'h01 && ofs[1:0] == 2'h0;
    wire logic mode_hit = in_win && ofs[11:7] == 5'h00 && ofs[1:0] == 2'h0;
    // shadow of the enable set, kept from the command writes alone
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            en_sh_ff <= RST_WORD;
        end else if (wr_en_in && in_win && ofs == OFS_ENABLE_CMD) begin
            en_sh_ff <= en_sh_ff | wr_data_in;
        end else if (wr_en_in && in_win && ofs == OFS_DISABLE_CMD) begin
            en_sh_ff <= en_sh_ff & ~wr_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            spu_sh_ff <= RST_WORD;
            vec0_sh_ff <= RST_WORD;
        end else if (wr_en_in && in_win) begin
            if (ofs == OFS_SPURIOUS) spu_sh_ff <= wr_data_in;
            if (ofs == OFS_VEC_FIRST) vec0_sh_ff <= wr_data_in;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_vec_wr_rd;
        wr_en_in && vec_hit ##1 rd_en_in && vec_hit && $stable(addr_in);
    endsequence
    sequence s_mode_wr_rd;
        wr_en_in && mode_hit ##1 rd_en_in && mode_hit && $stable(addr_in);
    endsequence
    a_vector_read_back: assert property (s_vec_wr_rd |=> rd_data_out == $past(wr_data_in, 2))
        else $error("vector register read back differs from write");
    a_mode_read_back: assert property (s_mode_wr_rd |=> rd_data_out == ($past(wr_data_in, 2) & MODE_WR_MASK))
        else $error("mode register read back differs from write");
    a_out_window_zero: assert property (rd_en_in && !in_win |=> rd_data_out == RST_WORD)
        else $error("read outside the window returned data");
    a_reserved_zero: assert property (rd_en_in && in_win && (ofs == 12'h118 || ofs == 12'h13C)
        |=> rd_data_out == RST_WORD)
        else $error("reserved offset returned data");
    a_status_field: assert property (rd_en_in && in_win && ofs == OFS_CUR_STATUS
        |=> rd_data_out[31:5] == 27'h0)
        else $error("status upper bits not zero");
    a_mask_readback: assert property (rd_en_in && in_win && ofs == OFS_MASK
        |=> rd_data_out == $past(en_sh_ff))
        else $error("mask read differs from enable commands");
    a_normal_needs_en: assert property (!normal_request_line_n_out |->
        ($past(en_sh_ff[31:1]) | $past(en_sh_ff[31:1], 2)) != 31'h0)
        else $error("normal line active with no source enabled");
    // the line one cycle after the read comes from the same request that chose the data
    a_fast_vector: assert property (rd_en_in && in_win && ofs == OFS_FAST_VEC
        |=> fast_request_line_n_out || rd_data_out == vec0_sh_ff)
        else $error("fast vector read did not return vector zero");
    a_ivr_spurious: assert property (rd_en_in && in_win && ofs == OFS_NORMAL_VEC && en_sh_ff == RST_WORD
        |=> rd_data_out == spu_sh_ff)
        else $error("vector read with nothing enabled not spurious");
endmodule

bind vic_top vic_assertions vic_assertions_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .normal_request_line_n_out(normal_request_line_n_out), .fast_request_line_n_out(fast_request_line_n_out));

// ===== vic_core_model.sv
// processor side model: watches both active low request lines
`timescale 1ns/100ps
module vic_core_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic normal_request_line_n_in,
    input wire logic fast_request_line_n_in,
    output logic normal_seen_out,
    output logic fast_seen_out
);
    // sticky so a short request is not missed between polls
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            normal_seen_out <= 1'b0;
            fast_seen_out <= 1'b0;
        end else begin
            normal_seen_out <= normal_seen_out | ~normal_request_line_n_in;
            fast_seen_out <= fast_seen_out | ~fast_request_line_n_in;
        end
    end
endmodule

// ===== vic_top_tb.sv
// self-checking bench for the controller register port and request lines
`timescale 1ns/100ps
module vic_top_tb import vic_pkg::*; ;
    localparam logic [11:0] RST_OFS [12] = '{12'h000, 12'h004, 12'h07C, 12'h080, 12'h084, 12'h0FC,
        12'h108, 12'h110, 12'h114, 12'h134, 12'h138, 12'h148};
    localparam int IDX [4] = '{0, 1, 17, 31};
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [31:0] addr_in = 32'h0;
    logic [31:0] wr_data_in = 32'h0;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    // external pins idle high except 31, held low to show its level at reset
    logic [31:0] src_in = 32'h6000_0001;
    logic [31:0] rd_data_out;
    logic normal_request_line_n_out;
    logic fast_request_line_n_out;
    logic event_irq_out;
    logic normal_seen;
    logic fast_seen;
    logic [31:0] got;
    logic [1:0] t;
    logic act;
    int s;
    int n_fail = 0;
    int checks = 0;
    always #25 clk_in = ~clk_in;
    vic_top vic_top_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .src_in(src_in), .rd_data_out(rd_data_out),
        .normal_request_line_n_out(normal_request_line_n_out), .fast_request_line_n_out(fast_request_line_n_out),
        .event_irq_out(event_irq_out));
    vic_core_model vic_core_model_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .normal_request_line_n_in(normal_request_line_n_out), .fast_request_line_n_in(fast_request_line_n_out),
        .normal_seen_out(normal_seen), .fast_seen_out(fast_seen));
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] o, input logic [31:0] d, input logic [31:0] base = BASE_ADDR);
        @(posedge clk_in);
        addr_in <= base | 32'(o);
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] o, output logic [31:0] q, input logic [31:0] base = BASE_ADDR);
        @(posedge clk_in);
        addr_in <= base | 32'(o);
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 q = rd_data_out;
    endtask
    task automatic rdc(input logic [11:0] o, input logic [31:0] e, input string what);
        logic [31:0] q;
        rd(o, q);
        chk(q, e, what);
    endtask
    // write then read the same place with no gap between strobes
    task automatic wr_rd(input logic [11:0] o, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= BASE_ADDR | 32'(o);
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 chk(rd_data_out, e, "read back");
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        foreach (RST_OFS[i]) rdc(RST_OFS[i], RST_WORD, "reset value");
        rdc(OFS_PENDING, 32'h8000_0000, "pending at reset");
        src_in[31] <= 1'b1;
        $display("test reset values done");
        foreach (IDX[i]) begin
            wr_rd(OFS_MODE_FIRST + 12'(4 * IDX[i]), 32'hFFFF_FFFF, MODE_WR_MASK);
            wr_rd(OFS_VEC_FIRST + 12'(4 * IDX[i]), 32'hA5A5_0000 | IDX[i], 32'hA5A5_0000 | IDX[i]);
        end
        rdc(12'h008, RST_WORD, "neighbour mode");
        wr(OFS_VEC_FIRST, 32'h1234_5678, 32'hFFFE_F000);
        rdc(OFS_VEC_FIRST, 32'hA5A5_0000, "write outside window");
        rd(OFS_VEC_FIRST, got, 32'h0000_0000);
        chk(got, RST_WORD, "read outside window");
        rdc(12'h118, RST_WORD, "reserved");
        $display("test register map done");
        for (int k = 0; k < 8; k++) begin
            s = (k < 4) ? 7 : 30;
            t = 2'(k);
            act = (s == 7) ? 1'b1 : t[1];
            src_in[s] <= ~act;
            wr(12'(4 * s), 32'(t) << TYPE_LSB);
            repeat (6) @(posedge clk_in);
            wr(OFS_CLEAR_CMD, 32'h1 << s);
            rd(OFS_PENDING, got);
            chk(32'(got[s]), 32'h0, "idle pending");
            src_in[s] <= act;
            repeat (6) @(posedge clk_in);
            rd(OFS_PENDING, got);
            chk(32'(got[s]), 32'h1, "active pending");
            src_in[s] <= ~act;
            repeat (6) @(posedge clk_in);
            rd(OFS_PENDING, got);
            chk(32'(got[s]), 32'(t[0]), "after release");
        end
        $display("test source types done");
        wr(OFS_SPURIOUS, 32'h0000_5A5A);
        rdc(OFS_NORMAL_VEC, 32'h0000_5A5A, "spurious vector");
        wr(12'h014, 32'h0000_0023);
        wr(12'h018, 32'h0000_0026);
        wr(12'h094, 32'h0000_0500);
        wr(12'h098, 32'h0000_0600);
        wr(OFS_ENABLE_CMD, 32'h0000_0060);
        wr(OFS_ENABLE_CMD, RST_WORD);
        rdc(OFS_MASK, 32'h0000_0060, "enable mask");
        src_in[5] <= 1'b1;
        wr(OFS_SET_CMD, 32'h0000_0040);
        repeat (4) @(posedge clk_in);
        chk(32'(normal_seen), 32'h1, "normal line");
        rdc(OFS_NORMAL_VEC, 32'h0000_0600, "higher level wins");
        rdc(OFS_CUR_STATUS, 32'h0000_0006, "current source");
        wr(OFS_END_SERVICE, 32'hDEAD_BEEF);
        rdc(OFS_NORMAL_VEC, 32'h0000_0500, "lower level next");
        rdc(OFS_CUR_STATUS, 32'h0000_0005, "current source");
        wr(OFS_END_SERVICE, RST_WORD);
        repeat (3) @(posedge clk_in);
        chk(32'(normal_request_line_n_out), 32'h1, "line released");
        $display("test normal flow done");
        rdc(OFS_FAST_VEC, 32'h0000_5A5A, "no fast request");
        // source 0 as high level, its pin already idles high
        wr(OFS_MODE_FIRST, 32'h0000_0040);
        wr(OFS_ENABLE_CMD, 32'h0000_0001);
        repeat (8) @(posedge clk_in);
        chk(32'(fast_seen), 32'h1, "fast line");
        rdc(OFS_FAST_VEC, 32'hA5A5_0000, "fast vector");
        wr(OFS_DISABLE_CMD, 32'h0000_0001);
        repeat (4) @(posedge clk_in);
        rdc(OFS_FAST_VEC, 32'h0000_5A5A, "fast gone");
        $display("test fast flow done");
        wr(OFS_FR_ENABLE, 32'h0000_0040);
        wr(OFS_SET_CMD, 32'h0000_0040);
        repeat (2) @(posedge clk_in);
        rdc(OFS_FR_STATUS, 32'h0000_0040, "redirect status");
        rdc(OFS_CORE_LINE, 32'h0000_0001, "redirected to fast line");
        rdc(OFS_FAST_VEC, 32'hA5A5_0000, "redirected fast vector");
        wr(OFS_DEBUG, 32'h0000_0002);
        rdc(OFS_CORE_LINE, RST_WORD, "general mask");
        chk(32'(fast_request_line_n_out), 32'h1, "fast line masked");
        wr(OFS_DEBUG, RST_WORD);
        wr(OFS_CLEAR_CMD, 32'h0000_0040);
        wr(OFS_FR_DISABLE, 32'h0000_0040);
        $display("test redirect and mask done");
        rd(OFS_EVENT_STATUS, got);
        wr(OFS_EVENT_MASK, RST_WORD);
        rd(OFS_NORMAL_VEC, got);
        repeat (2) @(posedge clk_in);
        chk(32'(event_irq_out), 32'h0, "masked event");
        wr(OFS_EVENT_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        chk(32'(event_irq_out), 32'h1, "event raised");
        rdc(OFS_EVENT_STATUS, 32'h0000_0001, "event status");
        repeat (2) @(posedge clk_in);
        chk(32'(event_irq_out), 32'h0, "event cleared");
        $display("test event interrupt done");
        close_out();
    end
    // the tests need well under a thousand cycles
    initial begin
        #200000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule
